// ==== ivpm_cpu_model.sv ====
`timescale 1ns/100ps
module ivpm_cpu_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Handshake with the controller
    input wire ivpm_pkg::ivpm_vec_s vec_i,
    input wire logic go_i,
    input wire logic [3:0] lat_i,
    output logic ack_o,
    output logic reti_o
);
    import ivpm_pkg::*;
    logic [3:0] cnt;
    wire logic waiting = go_i && vec_i.valid && !ack_o;
    // Fetch lat_i+1 cycles after the offer; ack only while the offer stands
    // handler return one cycle after fetch
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 4'h0;
            ack_o <= 1'h0;
            reti_o <= 1'h0;
        end else begin
            cnt <= waiting ? cnt + 4'h1 : 4'h0;
            ack_o <= waiting && cnt == lat_i;
            reti_o <= ack_o;
        end
    end
endmodule : ivpm_cpu_model

// ==== ivpm_ctrl.sv ====
`timescale 1ns/100ps
// Function
// [RQ1] Run state enables every clock and CPU
// [RQ2] Level zero: CPU, main off; others run
// [RQ3] Level one also drops unused oscillator generator
// [RQ4] Level two: main, submain off; generator on
// [RQ5] Level three: only auxiliary clock stays
// [RQ6] Level four: everything stopped, crystal off
// [RQ7] Enabled interrupt wakes; return restores level
// [RQ8] Vectors live at 0ffe0h to 0ffffh
// [RQ9] Reset sources use 0fffeh, priority 15
// [RQ10] Nonmaskable group shares 0fffch, priority 14
// [RQ11] Nonmaskable gated by own enable only
// [RQ12] Watchdog, timer vectors at fixed addresses
// [RQ13] Serial receive and transmit vectors
// [RQ14] Converter and port vectors fixed
// [RQ15] Shared vectors need flag read by handler
// [RQ16] Unassigned register bits have no storage
// [RQ17] Watchdog enable matters only in interval mode
// [RQ18] Watchdog flag set on overflow, bad key
// [RQ19] Watchdog flag cleared by power-up, pin reset
// [RQ20] Oscillator fault and pin event set flags
// [RQ21] Module enable two holds serial enables
// [RQ22] All eight port-two flags are honoured
// [RQ23] Port three raises no interrupts
// [RQ24] Highest-priority pending vector goes first; an offered vector is held and fetched first, only reset replaces it
// [RQ25] Unassigned vector slots never selected
module ivpm_ctrl (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic sfr_wr_i,
    input wire logic [3:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // CPU status and handshake
    input wire logic gie_i,
    input wire logic [2:0] mode_req_i,
    input wire logic mode_wr_i,
    input wire logic reti_i,
    input wire logic vec_ack_i,
    input wire logic dco_is_main_i,
    input wire logic wdt_interval_mode_i,
    input wire logic reset_pin_mode_i,
    // Peripheral sources
    input wire ivpm_pkg::ivpm_src_s src_i,
    // Outputs
    output ivpm_pkg::ivpm_vec_s vec_o,
    output ivpm_pkg::ivpm_clk_s clk_o,
    output logic [2:0] mode_o,
    output logic por_pending_o
);
    import ivpm_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] ie_one;
    logic [7:0] ie_two;
    logic [7:0] ifg_one;
    logic [7:0] ifg_two;
    logic [7:0] me_two;
    logic reset_latched;
    ivpm_mode_e mode;
    ivpm_mode_e saved_mode;
    logic in_handler;

    // Write decode
    wire wr_ie1 = ce_i && sfr_wr_i && (sfr_addr_i == IE_ONE_OFS);
    wire wr_ie2 = ce_i && sfr_wr_i && (sfr_addr_i == IE_TWO_OFS);
    wire wr_if1 = ce_i && sfr_wr_i && (sfr_addr_i == IFG_ONE_OFS);
    wire wr_if2 = ce_i && sfr_wr_i && (sfr_addr_i == IFG_TWO_OFS);
    wire wr_me2 = ce_i && sfr_wr_i && (sfr_addr_i == ME_TWO_OFS);

    // Hardware flag set terms; set beats a software clear in the same cycle
    logic [7:0] ifg1_set;
    logic [7:0] ifg2_set;
    always_comb begin
        ifg1_set = 8'h00;
        // [RQ18] watchdog flag set
        ifg1_set[WDT_BIT] = src_i.wdt_expire | src_i.key_violation_flag | src_i.wdt_interval;
        // [RQ20] fault and pin flags
        ifg1_set[OF_BIT] = src_i.osc_fault;
        ifg1_set[NMI_BIT] = src_i.nmi_pin_event;
        ifg2_set = 8'h00;
        ifg2_set[RX_BIT] = src_i.serial_rx_flag;
        ifg2_set[TX_BIT] = src_i.serial_tx_flag;
    end

    // [RQ19] watchdog flag clear on power-up or pin reset
    wire wdt_flag_clr = src_i.por | (src_i.reset_pin & reset_pin_mode_i);

    wire nmi_take;
    wire [7:0] next_ifg_one = (((wr_if1 ? sfr_wdata_i : ifg_one) | ifg1_set)
                               & IFG_ONE_MASK) & ~(wdt_flag_clr ? 8'h01 : 8'h00);

    // [RQ16] only implemented bits are stored
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ie_one <= SFR_RESET;
            ie_two <= SFR_RESET;
            ifg_one <= SFR_RESET;
            ifg_two <= SFR_RESET;
            me_two <= SFR_RESET;
        end else if (ce_i) begin
            if (wr_ie1) ie_one <= sfr_wdata_i & IE_ONE_MASK;
            else if (nmi_take) ie_one <= ie_one & ~8'h32;
            if (wr_ie2) ie_two <= sfr_wdata_i & IE_TWO_MASK;
            ifg_one <= next_ifg_one;
            ifg_two <= ((wr_if2 ? sfr_wdata_i : ifg_two) | ifg2_set) & IFG_TWO_MASK;
            // [RQ21] module enable two storage
            if (wr_me2) me_two <= sfr_wdata_i & ME_TWO_MASK;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (sfr_addr_i == IE_ONE_OFS) ? ie_one :
                        (sfr_addr_i == IE_TWO_OFS) ? ie_two :
                        (sfr_addr_i == IFG_ONE_OFS) ? ifg_one :
                        (sfr_addr_i == IFG_TWO_OFS) ? ifg_two :
                        (sfr_addr_i == ME_TWO_OFS) ? me_two : 8'h00;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) sfr_rdata_o <= 8'h00;
        else if (ce_i) sfr_rdata_o <= rd_mux;
    end

    // ------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------
    // [RQ9] reset group held until the CPU takes the vector
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) reset_latched <= 1'b1;
        else if (ce_i) begin
            if (src_i.por | src_i.reset_pin | src_i.wdt_expire | src_i.key_violation_flag)
                reset_latched <= 1'b1;
            else if (vec_ack_i && vec_o.prio == PRI_RESET) reset_latched <= 1'b0;
        end
    end

    // [RQ11] own enables only, no global gate
    wire req_nmi = (ifg_one[NMI_BIT] & ie_one[NMI_BIT]) | (ifg_one[OF_BIT] & ie_one[OF_BIT])
                 | (src_i.flash_violation_flag & ie_one[ACCV_BIT]);
    assign nmi_take = vec_ack_i && vec_o.valid && vec_o.prio == PRI_NMI;
    // [RQ17] watchdog enable only in interval mode
    wire req_wdt = gie_i & wdt_interval_mode_i & ifg_one[WDT_BIT] & ie_one[WDT_BIT];
    wire req_cc0 = gie_i & src_i.cc0_req;
    wire req_cc12 = gie_i & src_i.cc12_ovf_req;
    // [RQ13] serial requests
    wire req_rx = gie_i & ifg_two[RX_BIT] & ie_two[RX_BIT];
    wire req_tx = gie_i & ifg_two[TX_BIT] & ie_two[TX_BIT];
    wire req_adc = gie_i & src_i.converter_done_flag;
    // [RQ22] all eight port-two flags; [RQ23] no port three input
    wire req_p2 = gie_i & (|src_i.port_two_flags);
    wire req_p1 = gie_i & (|src_i.port_one_flags);

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    // [RQ24] highest first; [RQ25] empty slots never chosen
    ivpm_vec_s next_vec;
    always_comb begin
        next_vec = '0;
        // [RQ8] [RQ12] [RQ14] fixed table
        if (reset_latched) next_vec = '{1'b1, PRI_RESET, VEC_RESET};
        else if (req_nmi) next_vec = '{1'b1, PRI_NMI, VEC_NMI};
        else if (req_wdt) next_vec = '{1'b1, PRI_WDT, VEC_WDT};
        else if (req_cc0) next_vec = '{1'b1, PRI_CC0, VEC_CC0};
        else if (req_cc12) next_vec = '{1'b1, PRI_CC12, VEC_CC12};
        else if (req_rx) next_vec = '{1'b1, PRI_RX, VEC_RX};
        else if (req_tx) next_vec = '{1'b1, PRI_TX, VEC_TX};
        else if (req_adc) next_vec = '{1'b1, PRI_ADC, VEC_ADC};
        // [RQ15] shared vectors leave source flags intact
        else if (req_p2) next_vec = '{1'b1, PRI_P2, VEC_P2};
        else if (req_p1) next_vec = '{1'b1, PRI_P1, VEC_P1};
    end

    // An offer stands until the CPU fetches it, so a flag cleared by the
    // handler cannot pull a vector away mid-fetch; only reset may replace it
    wire hold_offer = vec_o.valid && !reset_latched;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) vec_o <= '0;
        else if (ce_i) vec_o <= vec_ack_i ? '0 : hold_offer ? vec_o : next_vec;
    end

    // ------------------------------------------------------------
    // Power mode sequencing
    // ------------------------------------------------------------
    wire wake = next_vec.valid;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode <= RUN_STATE;
            saved_mode <= RUN_STATE;
            in_handler <= 1'b0;
        end else if (ce_i) begin
            if (mode != RUN_STATE && wake) begin
                // [RQ7] wake and remember level
                saved_mode <= mode;
                mode <= RUN_STATE;
                in_handler <= 1'b1;
            end else if (reti_i && in_handler) begin
                // [RQ7] restore on return
                mode <= saved_mode;
                in_handler <= 1'b0;
            end else if (mode_wr_i && mode == RUN_STATE && mode_req_i <= 3'b101) begin
                mode <= ivpm_mode_e'(mode_req_i);
            end
        end
    end

    // Clock gates per mode
    ivpm_clk_s next_clk;
    always_comb begin
        next_clk = '1;
        unique case (mode)
            // [RQ1] all running
            RUN_STATE: next_clk = '1;
            // [RQ2] CPU and main stopped
            SLEEP_LEVEL_ZERO: next_clk = 6'b001111;
            // [RQ3] generator off if unused
            SLEEP_LEVEL_ONE: next_clk = {4'b0011, dco_is_main_i, 1'b1};
            // [RQ4] generator on
            SLEEP_LEVEL_TWO: next_clk = 6'b000111;
            // [RQ5] auxiliary only
            SLEEP_LEVEL_THREE: next_clk = 6'b000101;
            // [RQ6] all stopped
            SLEEP_LEVEL_FOUR: next_clk = 6'b000000;
            default: next_clk = '1;
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) clk_o <= '1;
        else if (ce_i) clk_o <= next_clk;
    end

    assign mode_o = mode;
    assign por_pending_o = reset_latched;
endmodule : ivpm_ctrl

// ==== ivpm_pkg.sv ====
package ivpm_pkg;
    // Special-function register byte offsets
    localparam logic [3:0] IE_ONE_OFS = 4'h0;
    localparam logic [3:0] IE_TWO_OFS = 4'h1;
    localparam logic [3:0] IFG_ONE_OFS = 4'h2;
    localparam logic [3:0] IFG_TWO_OFS = 4'h3;
    localparam logic [3:0] ME_ONE_OFS = 4'h4;
    localparam logic [3:0] ME_TWO_OFS = 4'h5;
    // Bit positions
    localparam int WDT_BIT = 0;
    localparam int OF_BIT = 1;
    localparam int NMI_BIT = 4;
    localparam int ACCV_BIT = 5;
    localparam int RX_BIT = 0;
    localparam int TX_BIT = 1;
    localparam int SPI_BIT = 0;
    // Implemented-bit masks
    localparam logic [7:0] IE_ONE_MASK = 8'h33;
    localparam logic [7:0] IFG_ONE_MASK = 8'h13;
    localparam logic [7:0] IE_TWO_MASK = 8'h03;
    localparam logic [7:0] IFG_TWO_MASK = 8'h03;
    localparam logic [7:0] ME_ONE_MASK = 8'h00;
    localparam logic [7:0] ME_TWO_MASK = 8'h03;
    localparam logic [7:0] SFR_RESET = 8'h00;
    // Vector word addresses
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    localparam logic [15:0] VEC_WDT = 16'hfff4;
    localparam logic [15:0] VEC_CC0 = 16'hfff2;
    localparam logic [15:0] VEC_CC12 = 16'hfff0;
    localparam logic [15:0] VEC_RX = 16'hffee;
    localparam logic [15:0] VEC_TX = 16'hffec;
    localparam logic [15:0] VEC_ADC = 16'hffea;
    localparam logic [15:0] VEC_P2 = 16'hffe6;
    localparam logic [15:0] VEC_P1 = 16'hffe4;
    // Priorities
    localparam logic [3:0] PRI_RESET = 4'hf;
    localparam logic [3:0] PRI_NMI = 4'he;
    localparam logic [3:0] PRI_WDT = 4'ha;
    localparam logic [3:0] PRI_CC0 = 4'h9;
    localparam logic [3:0] PRI_CC12 = 4'h8;
    localparam logic [3:0] PRI_RX = 4'h7;
    localparam logic [3:0] PRI_TX = 4'h6;
    localparam logic [3:0] PRI_ADC = 4'h5;
    localparam logic [3:0] PRI_P2 = 4'h3;
    localparam logic [3:0] PRI_P1 = 4'h2;

    typedef enum logic [2:0] {
        RUN_STATE = 3'b000,
        SLEEP_LEVEL_ZERO = 3'b001,
        SLEEP_LEVEL_ONE = 3'b010,
        SLEEP_LEVEL_TWO = 3'b011,
        SLEEP_LEVEL_THREE = 3'b100,
        SLEEP_LEVEL_FOUR = 3'b101
    } ivpm_mode_e;

    // Clock gate controls
    typedef struct packed {
        logic cpu_run;
        logic main_clk_en;
        logic submain_clock_en;
        logic aux_clk_en;
        logic digital_osc_dc_en;
        logic crystal_en;
    } ivpm_clk_s;

    // Peripheral event pulses and level requests
    typedef struct packed {
        logic por;
        logic reset_pin;
        logic wdt_expire;
        logic key_violation_flag;
        logic wdt_interval;
        logic nmi_pin_event;
        logic osc_fault;
        logic flash_violation_flag;
        logic serial_rx_flag;
        logic serial_tx_flag;
        logic cc0_req;
        logic cc12_ovf_req;
        logic converter_done_flag;
        logic [7:0] port_one_flags;
        logic [7:0] port_two_flags;
    } ivpm_src_s;

    // Vector offer to the CPU
    typedef struct packed {
        logic valid;
        logic [3:0] prio;
        logic [15:0] addr;
    } ivpm_vec_s;
endpackage : ivpm_pkg

// ==== ivpm_props.sv ====
`timescale 1ns/100ps
module ivpm_props (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Watched ports
    input wire logic [3:0] sfr_addr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic vec_ack_i,
    input wire logic dco_is_main_i,
    input wire ivpm_pkg::ivpm_vec_s vec_o,
    input wire ivpm_pkg::ivpm_clk_s clk_o,
    input wire logic [2:0] mode_o
);
    import ivpm_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // -------------------------------------------
    // Expected gates and readable bits
    // -------------------------------------------
    function automatic logic [5:0] gate_of(input logic [2:0] m, input logic d);
        case (m)
            SLEEP_LEVEL_ZERO: return 6'h0f;
            SLEEP_LEVEL_ONE: return {4'h3, d, 1'h1};
            SLEEP_LEVEL_TWO: return 6'h07;
            SLEEP_LEVEL_THREE: return 6'h05;
            SLEEP_LEVEL_FOUR: return 6'h00;
            default: return 6'h3f;
        endcase
    endfunction : gate_of
    // Offsets above five are not judged
    function automatic logic [7:0] mask_of(input logic [3:0] a);
        case (a)
            IE_ONE_OFS: return IE_ONE_MASK;
            IE_TWO_OFS: return IE_TWO_MASK;
            IFG_ONE_OFS: return IFG_ONE_MASK;
            IFG_TWO_OFS: return IFG_TWO_MASK;
            ME_ONE_OFS: return ME_ONE_MASK;
            ME_TWO_OFS: return ME_TWO_MASK;
            default: return 8'hff;
        endcase
    endfunction : mask_of
    a_vec_range: assert property (vec_o.valid |-> vec_o.addr[15:5] == 11'h7ff)
        else $error("vector outside table");
    a_vec_prio: assert property (vec_o.valid |-> vec_o.prio == vec_o.addr[4:1])
        else $error("priority does not match vector slot");
    a_no_spare: assert property (vec_o.valid |->
        !(vec_o.addr[4:1] inside {4'hd, 4'hc, 4'hb, 4'h4, 4'h1, 4'h0}))
        else $error("unassigned vector slot offered");
    a_clk_gating: assert property ($stable(mode_o) && $stable(dco_is_main_i)
        |-> clk_o == gate_of(mode_o, dco_is_main_i))
        else $error("clock gates wrong for mode");
    a_ack_clears: assert property (ce_i && vec_ack_i && vec_o.valid |=> !vec_o.valid)
        else $error("vector not withdrawn after fetch");
    a_vec_stands: assert property (ce_i && vec_o.valid && !vec_ack_i |=> vec_o.valid)
        else $error("vector dropped before fetch");
    a_wake_runs: assert property (vec_o.valid [*3] |-> clk_o.cpu_run)
        else $error("pending vector did not wake cpu");
    a_unused_bits: assert property (1'h1 |->
        (sfr_rdata_o & ~mask_of($past(sfr_addr_i))) == 8'h00)
        else $error("absent register bit reads one");
    c_rx_vec: cover property (vec_o.valid && vec_o.addr == VEC_RX);
    c_deep_sleep: cover property (mode_o == SLEEP_LEVEL_FOUR);
    c_nmi_fetch: cover property (vec_ack_i && vec_o.valid && vec_o.addr == VEC_NMI);
endmodule : ivpm_props

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
    import ivpm_pkg::*;
    logic mclk_i, reset_n_i, ce_i, sfr_wr_i, gie_i, mode_wr_i, reti_i, vec_ack_i, go;
    logic dco_is_main_i, wdt_interval_mode_i, reset_pin_mode_i, por_pending_o;
    logic [3:0] sfr_addr_i, lat;
    logic [7:0] sfr_wdata_i, sfr_rdata_o;
    logic [2:0] mode_req_i, mode_o;
    ivpm_src_s src_i;
    ivpm_vec_s vec_o;
    ivpm_clk_s clk_o;
    int n_errors = 0;
    int n_tests = 0;
    logic [7:0] masks [6] = '{IE_ONE_MASK, IE_TWO_MASK, IFG_ONE_MASK, IFG_TWO_MASK,
        ME_ONE_MASK, ME_TWO_MASK};
    logic [19:0] chain [5] = '{{PRI_CC0, VEC_CC0}, {PRI_CC12, VEC_CC12},
        {PRI_ADC, VEC_ADC}, {PRI_P2, VEC_P2}, {PRI_P1, VEC_P1}};
    logic [2:0] mreq [6] = '{SLEEP_LEVEL_ZERO, SLEEP_LEVEL_ONE, SLEEP_LEVEL_ONE,
        SLEEP_LEVEL_TWO, SLEEP_LEVEL_FOUR, SLEEP_LEVEL_THREE};
    logic dco_tab [6] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
    logic [5:0] gates [6] = '{6'h0f, 6'h0d, 6'h0f, 6'h07, 6'h00, 6'h05};
    ivpm_ctrl u_ivpm_ctrl (.mclk_i, .reset_n_i, .ce_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i,
        .sfr_rdata_o, .gie_i, .mode_req_i, .mode_wr_i, .reti_i, .vec_ack_i, .dco_is_main_i,
        .wdt_interval_mode_i, .reset_pin_mode_i, .src_i, .vec_o, .clk_o, .mode_o,
        .por_pending_o);
    ivpm_cpu_model u_ivpm_cpu_model (.mclk_i, .reset_n_i, .vec_i(vec_o), .go_i(go),
        .lat_i(lat), .ack_o(vec_ack_i), .reti_o(reti_i));
    // ------------------------------------
    // Bus and handshake tasks
    // ------------------------------------
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // Inputs move 1 ns after the edge so the design samples settled values
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'h1;
        tick(1);
        sfr_wr_i = 1'h0;
        // Let an edge pass so back-to-back writes never retoggle the strobe
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        sfr_addr_i = a;
        tick(1);
        check(21'(sfr_rdata_o), 21'(e));
    endtask : rd
    task automatic see(input logic [15:0] a, input logic [3:0] p);
        for (int i = 0; i < 20 && vec_o.valid !== 1'h1; i++)
            tick(1);
        check(21'(vec_o), {1'h1, p, a});
    endtask : see
    // The model fetches; wait for its ack, then let the withdrawal land
    task automatic ack();
        go = 1'h1;
        for (int i = 0; i < 30 && vec_ack_i !== 1'h1; i++)
            tick(1);
        go = 1'h0;
        tick(1);
    endtask : ack
    task automatic do_reset();
        reset_n_i = 1'h0;
        tick(2);
        reset_n_i = 1'h1;
        see(VEC_RESET, PRI_RESET);
        check(21'(por_pending_o), 21'h1);
        ack();
    endtask : do_reset
    task automatic stop_test();
        $display("Checks: %0d, errors: %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // Clock and watchdog
    initial begin
        mclk_i = 1'h0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        stop_test();
    end
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    initial begin
        {reset_n_i, sfr_wr_i, gie_i, mode_wr_i, go, dco_is_main_i} = 6'h00;
        {wdt_interval_mode_i, reset_pin_mode_i, sfr_addr_i, lat} = 10'h000;
        {sfr_wdata_i, mode_req_i} = 11'h000;
        src_i = '0;
        ce_i = 1'h1;
        do_reset();
        for (int a = 0; a < 6; a++) begin
            wr(4'(a), 8'hff);
            rd(4'(a), masks[a]);
            wr(4'(a), 8'h00);
        end
        wr(IE_ONE_OFS, 8'h10);
        src_i.nmi_pin_event = 1'h1;
        tick(1);
        src_i.nmi_pin_event = 1'h0;
        see(VEC_NMI, PRI_NMI);
        ack();
        rd(IFG_ONE_OFS, 8'h10);
        wr(IFG_ONE_OFS, 8'h00);
        wr(IE_TWO_OFS, 8'h01);
        src_i.serial_rx_flag = 1'h1;
        tick(1);
        src_i.serial_rx_flag = 1'h0;
        tick(3);
        check(21'(vec_o.valid), 21'h0);
        gie_i = 1'h1;
        see(VEC_RX, PRI_RX);
        wr(IFG_TWO_OFS, 8'h00);
        ack();
        tick(3);
        check(21'(vec_o.valid), 21'h0);
        lat = 4'h5;
        src_i.cc0_req = 1'h1;
        src_i.cc12_ovf_req = 1'h1;
        src_i.converter_done_flag = 1'h1;
        src_i.port_two_flags = 8'h80;
        src_i.port_one_flags = 8'h01;
        for (int k = 0; k < 5; k++) begin
            see(chain[k][15:0], chain[k][19:16]);
            case (k)
                0: src_i.cc0_req = 1'h0;
                1: src_i.cc12_ovf_req = 1'h0;
                2: src_i.converter_done_flag = 1'h0;
                3: src_i.port_two_flags = 8'h00;
                default: src_i.port_one_flags = 8'h00;
            endcase
            ack();
        end
        lat = 4'h0;
        src_i.wdt_expire = 1'h1;
        tick(1);
        src_i.wdt_expire = 1'h0;
        see(VEC_RESET, PRI_RESET);
        ack();
        rd(IFG_ONE_OFS, 8'h01);
        reset_pin_mode_i = 1'h1;
        src_i.reset_pin = 1'h1;
        tick(1);
        src_i.reset_pin = 1'h0;
        see(VEC_RESET, PRI_RESET);
        ack();
        rd(IFG_ONE_OFS, 8'h00);
        for (int k = 0; k < 6; k++) begin
            do_reset();
            check(21'(clk_o), 21'h3f);
            dco_is_main_i = dco_tab[k];
            mode_req_i = mreq[k];
            mode_wr_i = 1'h1;
            tick(1);
            mode_wr_i = 1'h0;
            tick(2);
            check(21'(clk_o), 21'(gates[k]));
        end
        ce_i = 1'h0;
        wr(IE_TWO_OFS, 8'h03);
        ce_i = 1'h1;
        rd(IE_TWO_OFS, 8'h00);
        wr(IE_TWO_OFS, 8'h02);
        src_i.serial_tx_flag = 1'h1;
        tick(1);
        src_i.serial_tx_flag = 1'h0;
        see(VEC_TX, PRI_TX);
        tick(2);
        check(21'(clk_o.cpu_run), 21'h1);
        wr(IFG_TWO_OFS, 8'h00);
        ack();
        tick(4);
        check(21'(mode_o), 21'(SLEEP_LEVEL_THREE));
        check(21'(clk_o), 21'h05);
        stop_test();
    end
endmodule : tb
bind ivpm_ctrl ivpm_props u_ivpm_props (.mclk_i, .reset_n_i, .ce_i, .sfr_addr_i,
    .sfr_rdata_o, .vec_ack_i, .dco_is_main_i, .vec_o, .clk_o, .mode_o);
